// ### design/alu_ops_pkg.sv
// Package: operation codes, flag layout and reset values for the execute slice
// Operation
// - Working minus memory via complement plus one
// - Swap memory nibbles into working, no flags
// - Null memory skips: discard prefetch, 2 cycles
// - Load working, skip when loaded byte null
// - Null selected bit skips, else 1 cycle
// - Working xor memory into working, null flag
// - Memory xor working into memory, null flag
`default_nettype none
package alu_ops_pkg;

  localparam int DATA_W = 8;
  localparam int BIT_SEL_W = 3;
  localparam int NIB_W = 4;

  // Flag vector bit positions
  localparam int FLG_BORROW_OUT = 0;
  localparam int FLG_NIBBLE_BORROW = 1;
  localparam int FLG_NULL = 2;
  localparam int FLG_SIGNED_WRAP = 3;
  localparam int FLG_W = 4;

  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [FLG_W-1:0] FLG_RST = 4'h0;

  // Cycles taken by a skipping and a non-skipping test
  localparam int SKIP_CYCLES = 2;
  localparam int PLAIN_CYCLES = 1;

  typedef enum logic [3:0] {
    op_idle,
    op_minus_working,
    minus_memory_into_memory,
    op_minus_immediate,
    nibble_exchange_into_working,
    skip_on_null_memory,
    load_and_skip_on_null,
    op_skip_on_null_bit,
    op_exclusive_or_working,
    exclusive_or_into_memory,
    op_exclusive_or_immediate
  } op_t;

endpackage
`default_nettype wire

// ### design/alu_core_if.sv
// Interface: operands to and results from the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface alu_core_if;
  import alu_ops_pkg::*;
  logic [DATA_W-1:0] lhs;
  logic [DATA_W-1:0] rhs;
  logic [DATA_W-1:0] diff;
  logic [DATA_W-1:0] xored;
  logic borrow_out;
  logic nibble_borrow;
  logic signed_wrap;

  modport unit (input lhs, input rhs, output diff, output xored, output borrow_out,
                output nibble_borrow, output signed_wrap);
  modport user (output lhs, output rhs, input diff, input xored, input borrow_out,
                input nibble_borrow, input signed_wrap);
endinterface
`default_nettype wire

// ### design/alu_arith_unit.sv
// Arithmetic unit: subtract by ones complement plus one, and bitwise xor
`timescale 1ns/1ps
`default_nettype none
module alu_arith_unit
  import alu_ops_pkg::*;
(
  alu_core_if.unit bus // Operands in, results out
);
  logic [NIB_W:0] low_sum;
  logic [DATA_W:0] full_sum;
  logic [DATA_W-1:0] rhs_inv;

  // Difference as lhs plus inverted rhs plus one; carries mean no borrow
  always_comb begin
    rhs_inv = ~bus.rhs;
    low_sum = {1'b0, bus.lhs[NIB_W-1:0]} + {1'b0, rhs_inv[NIB_W-1:0]} + 5'h01;
    full_sum = {1'b0, bus.lhs} + {1'b0, rhs_inv} + 9'h001;
  end

  // Results and flags
  assign bus.diff = full_sum[DATA_W-1:0];
  assign bus.borrow_out = full_sum[DATA_W];
  assign bus.nibble_borrow = low_sum[NIB_W];
  assign bus.signed_wrap = (bus.lhs[DATA_W-1] != bus.rhs[DATA_W-1]) &&
                           (full_sum[DATA_W-1] != bus.lhs[DATA_W-1]);
  assign bus.xored = bus.lhs ^ bus.rhs;
endmodule
`default_nettype wire

// ### design/alu_exec_slice.sv
// Execute slice: working register, flags, memory write-back and skip timing
`timescale 1ns/1ps
`default_nettype none
module alu_exec_slice
  import alu_ops_pkg::*;
(
  input wire logic core_clk, // Instruction cycle clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic op_valid, // Instruction offered this cycle
  input wire op_t op_code, // Operation to execute
  input wire logic [DATA_W-1:0] mem_data, // Addressed data byte
  input wire logic [DATA_W-1:0] imm_data, // Immediate constant
  input wire logic [BIT_SEL_W-1:0] bit_sel, // Bit under test
  output logic op_ready, // Slice can take an instruction
  output logic [DATA_W-1:0] acc, // Working register
  output logic [FLG_W-1:0] flags, // Wrap, null, nibble borrow, borrow out
  output logic mem_wr_en, // Write-back strobe to data memory
  output logic [DATA_W-1:0] mem_wr_data, // Write-back byte
  output logic discard_prefetch // Prefetched instruction is dropped
);
  alu_core_if core ();

  // Working register state
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] acc_nxt;
  // Flag state
  logic [FLG_W-1:0] flags_r;
  logic [FLG_W-1:0] flags_nxt;
  // Write-back state
  logic mem_wr_en_r;
  logic mem_wr_en_nxt;
  logic [DATA_W-1:0] mem_wr_data_r;
  logic [DATA_W-1:0] mem_wr_data_nxt;
  // Dummy cycle state
  logic dummy_r;
  logic dummy_nxt;

  // Decode and datapath helpers
  logic take;
  logic skip;
  logic is_minus;
  logic is_minus_to_mem;
  logic is_swap;
  logic is_skip_mem;
  logic is_load_skip;
  logic is_skip_bit;
  logic is_xor_to_acc;
  logic is_xor_to_mem;
  logic use_imm;
  logic mem_null;
  logic bit_null;
  wire logic [DATA_W-1:0] bit_lane;
  logic [DATA_W-1:0] swapped;

  alu_arith_unit u_arith (
    .bus(core.unit)
  );

  // A dummy cycle blocks the next instruction
  assign op_ready = !dummy_r;
  assign take = op_valid && op_ready;

  // Instruction decode, one class flag per operation group
  always_comb begin
    is_minus = 1'b0;
    is_minus_to_mem = 1'b0;
    is_swap = 1'b0;
    is_skip_mem = 1'b0;
    is_load_skip = 1'b0;
    is_skip_bit = 1'b0;
    is_xor_to_acc = 1'b0;
    is_xor_to_mem = 1'b0;
    use_imm = 1'b0;
    case (op_code)
      op_minus_working: begin
        is_minus = 1'b1;
      end
      minus_memory_into_memory: begin
        is_minus = 1'b1;
        is_minus_to_mem = 1'b1;
      end
      op_minus_immediate: begin
        is_minus = 1'b1;
        use_imm = 1'b1;
      end
      nibble_exchange_into_working: begin
        is_swap = 1'b1;
      end
      skip_on_null_memory: begin
        is_skip_mem = 1'b1;
      end
      load_and_skip_on_null: begin
        is_load_skip = 1'b1;
      end
      op_skip_on_null_bit: begin
        is_skip_bit = 1'b1;
      end
      op_exclusive_or_working: begin
        is_xor_to_acc = 1'b1;
      end
      op_exclusive_or_immediate: begin
        is_xor_to_acc = 1'b1;
        use_imm = 1'b1;
      end
      exclusive_or_into_memory: begin
        is_xor_to_mem = 1'b1;
      end
      default: begin
        use_imm = 1'b0;
      end
    endcase
  end

  // Operand selection; immediate forms take the instruction's constant
  always_comb begin
    core.lhs = acc_r;
    core.rhs = use_imm ? imm_data : mem_data;
  end

  // Nibble exchange of the addressed byte; the byte itself is left alone
  assign swapped = {mem_data[NIB_W-1:0], mem_data[DATA_W-1:NIB_W]};

  // One lane per data bit: set when that bit is selected and clear
  for (genvar gi = 0; gi < DATA_W; gi++) begin : g_lane
    assign bit_lane[gi] = (bit_sel == BIT_SEL_W'(gi)) && !mem_data[gi];
  end

  // Null tests feeding the skip decision
  assign mem_null = (mem_data == '0);
  assign bit_null = |bit_lane;

  // A taken test on a null byte or bit drops the prefetched instruction
  assign skip = take && ((is_skip_mem && mem_null) ||
                         (is_load_skip && mem_null) ||
                         (is_skip_bit && bit_null));

  // Next working register; memory-destination forms leave it alone
  always_comb begin
    acc_nxt = acc_r;
    if (take) begin
      if (is_minus && !is_minus_to_mem) begin
        acc_nxt = core.diff;
      end else if (is_swap) begin
        acc_nxt = swapped;
      end else if (is_load_skip) begin
        acc_nxt = mem_data;
      end else if (is_xor_to_acc) begin
        acc_nxt = core.xored;
      end
    end
  end

  // Working register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      acc_r <= ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Next flags: subtraction sets four, exclusive-or only the null flag
  always_comb begin
    flags_nxt = flags_r;
    if (take && is_minus) begin
      flags_nxt[FLG_BORROW_OUT] = core.borrow_out;
      flags_nxt[FLG_NIBBLE_BORROW] = core.nibble_borrow;
      flags_nxt[FLG_SIGNED_WRAP] = core.signed_wrap;
      flags_nxt[FLG_NULL] = (core.diff == '0);
    end else if (take && (is_xor_to_acc || is_xor_to_mem)) begin
      flags_nxt[FLG_NULL] = (core.xored == '0);
    end
  end

  // Flags
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flags_r <= FLG_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Next write-back: memory forms strobe for one cycle, the byte holds
  always_comb begin
    mem_wr_en_nxt = 1'b0;
    mem_wr_data_nxt = mem_wr_data_r;
    if (take && is_minus_to_mem) begin
      mem_wr_en_nxt = 1'b1;
      mem_wr_data_nxt = core.diff;
    end else if (take && is_xor_to_mem) begin
      mem_wr_en_nxt = 1'b1;
      mem_wr_data_nxt = core.xored;
    end
  end

  // Write-back strobe and byte
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mem_wr_en_r <= 1'b0;
      mem_wr_data_r <= ACC_RST;
    end else begin
      mem_wr_en_r <= mem_wr_en_nxt;
      mem_wr_data_r <= mem_wr_data_nxt;
    end
  end

  // Next dummy flag: a skip costs exactly one extra cycle
  always_comb begin
    dummy_nxt = skip;
  end

  // Dummy cycle flag
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dummy_r <= 1'b0;
    end else begin
      dummy_r <= dummy_nxt;
    end
  end

  // Outputs from flip-flops
  assign acc = acc_r;
  assign flags = flags_r;
  assign mem_wr_en = mem_wr_en_r;
  assign mem_wr_data = mem_wr_data_r;
  assign discard_prefetch = dummy_r;
endmodule
`default_nettype wire

// ### dv/alu_exec_slice_checker.sv
// Checker: result and skip timing properties of the execute slice
`timescale 1ns/1ps
`default_nettype none
module alu_exec_slice_checker
  import alu_ops_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic op_valid, // Offer
  input wire op_t op_code, // Op
  input wire logic [DATA_W-1:0] mem_data, // Byte
  input wire logic [DATA_W-1:0] imm_data, // Constant
  input wire logic [BIT_SEL_W-1:0] bit_sel, // Bit
  input wire logic op_ready, // Ready
  input wire logic [DATA_W-1:0] acc, // Working
  input wire logic [FLG_W-1:0] flags, // Flags
  input wire logic mem_wr_en, // Write
  input wire logic [DATA_W-1:0] mem_wr_data, // Write byte
  input wire logic discard_prefetch // Discard
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Instruction taken this edge
  wire logic tk = op_valid && op_ready;
  // Dummy cycle, then ready again
  sequence dummy_s;
    discard_prefetch && !op_ready ##1 !discard_prefetch && op_ready;
  endsequence
  minus_work_a: assert property (tk && op_code == op_minus_working |=>
    acc == $past(acc) - $past(mem_data)) else $error("minus result wrong");
  swap_nib_a: assert property (tk && op_code == nibble_exchange_into_working |=>
    acc == {$past(mem_data[3:0]), $past(mem_data[7:4])} && flags == $past(flags))
    else $error("swap wrong");
  skip_null_a: assert property (tk && op_code == skip_on_null_memory && mem_data == 8'h00
    |=> dummy_s) else $error("skip timing wrong");
  load_skip_a: assert property (tk && op_code == load_and_skip_on_null |=>
    acc == $past(mem_data)) else $error("load wrong");
  bit_keep_a: assert property (tk && op_code == op_skip_on_null_bit && mem_data[bit_sel]
    |=> !discard_prefetch && op_ready) else $error("bit skip wrong");
  xor_work_a: assert property (tk && op_code == op_exclusive_or_working |=>
    acc == ($past(acc) ^ $past(mem_data)) && flags[FLG_NULL] == (acc == 8'h00))
    else $error("xor result wrong");
  xor_mem_a: assert property (tk && op_code == exclusive_or_into_memory |=>
    mem_wr_en && mem_wr_data == ($past(acc) ^ $past(mem_data))) else $error("xor write wrong");
  minus_mem_a: assert property (tk && op_code == minus_memory_into_memory |=>
    mem_wr_en && mem_wr_data == $past(acc) - $past(mem_data) && $stable(acc))
    else $error("minus write wrong");
  bit_skip_a: assert property (tk && op_code == op_skip_on_null_bit && !mem_data[bit_sel]
    |=> dummy_s) else $error("bit skip timing wrong");
  load_null_a: assert property (tk && op_code == load_and_skip_on_null && mem_data == 8'h00
    |=> dummy_s) else $error("load skip timing wrong");
  minus_imm_a: assert property (tk && op_code == op_minus_immediate |=>
    acc == $past(acc) - $past(imm_data)) else $error("minus immediate wrong");
  borrow_flag_a: assert property (tk && op_code == op_minus_working |=>
    flags[FLG_BORROW_OUT] == ($past(acc) >= $past(mem_data))) else $error("borrow flag wrong");
endmodule
bind alu_exec_slice alu_exec_slice_checker u_chk (.core_clk, .rst_b, .op_valid, .op_code,
  .mem_data, .imm_data, .bit_sel, .op_ready, .acc, .flags, .mem_wr_en, .mem_wr_data,
  .discard_prefetch);
`default_nettype wire

// ### dv/mcu_alu_skip_swap_xor_ops_bench.sv
// Bench: random instruction stream checked against a reference model
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, s) begin total_checks++; if ((e) !== (s)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module mcu_alu_skip_swap_xor_ops_bench import alu_ops_pkg::*;;
  logic core_clk = 0, rst_b = 0, op_valid = 0, op_ready, mem_wr_en, discard_prefetch, tkd = 0;
  op_t op_code = op_idle;
  logic [7:0] mem_data = 8'h00, imm_data = 8'h00, acc, mem_wr_data, ea = ACC_RST, ewd = 8'h00;
  logic [2:0] bit_sel = 3'h0;
  logic [3:0] ef = FLG_RST;
  logic [3:0] flags;
  logic [21:0] q[$];
  logic [21:0] n;
  int fails = 0, total_checks = 0;
  alu_exec_slice u_alu_exec_slice (.core_clk, .rst_b, .op_valid, .op_code, .mem_data,
    .imm_data, .bit_sel, .op_ready, .acc, .flags, .mem_wr_en, .mem_wr_data, .discard_prefetch);
  // Clock at 4 ns
  initial forever #2 core_clk = ~core_clk;
  // Offer one instruction and note its expected result
  task automatic drive(input op_t o, input logic [7:0] m, x, input logic [2:0] b);
    logic [7:0] s;
    logic [8:0] r;
    logic [4:0] hn;
    logic we, dk;
    we = 0;
    dk = 0;
    @(negedge core_clk);
    while (op_ready !== 1'b1) @(negedge core_clk);
    op_valid = 1; op_code = o; mem_data = m; imm_data = x; bit_sel = b;
    s = (o == op_minus_immediate || o == op_exclusive_or_immediate) ? x : m;
    r = {1'b0, ea} + {1'b0, ~s} + 9'h001;
    hn = {1'b0, ea[3:0]} + {1'b0, ~s[3:0]} + 5'h01;
    case (o)
      op_minus_working, minus_memory_into_memory, op_minus_immediate: begin
        ef = {(ea[7] != s[7]) && (r[7] != ea[7]), r[7:0] == 8'h00, hn[4], r[8]};
        if (o == minus_memory_into_memory) begin we = 1; ewd = r[7:0]; end else ea = r[7:0];
      end
      nibble_exchange_into_working: ea = {m[3:0], m[7:4]};
      skip_on_null_memory: dk = (m == 8'h00);
      load_and_skip_on_null: begin ea = m; dk = (m == 8'h00); end
      op_skip_on_null_bit: dk = !m[b];
      op_exclusive_or_working, op_exclusive_or_immediate: begin
        ea = ea ^ s; ef[FLG_NULL] = (ea == 8'h00);
      end
      exclusive_or_into_memory: begin we = 1; ewd = ea ^ m; ef[FLG_NULL] = (ewd == 8'h00); end
      default: ;
    endcase
    q.push_back({ea, ef, we, ewd, dk});
  endtask
  // Compare each taken instruction's outcome with the oldest note
  always @(posedge core_clk) tkd <= op_valid && op_ready && rst_b;
  always @(negedge core_clk) if (tkd) begin
    n = q.pop_front();
    `CK("result", n, {acc, flags, mem_wr_en, mem_wr_data, discard_prefetch})
  end
  // Random instruction stream, then let the last result drain
  task automatic run_stream(input int count);
    repeat (count) drive(op_t'(4'($urandom % 11)), ($urandom % 3 == 0) ? 8'h00 : 8'($urandom),
      8'($urandom), 3'($urandom));
    @(negedge core_clk);
    op_valid = 0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence: reset, random stream, mid-run reset, second stream from reset values
  initial begin
    void'($urandom(45));
    repeat (12) @(negedge core_clk);
    rst_b = 1;
    drive(skip_on_null_memory, 8'h00, 8'h00, 3'h0);
    run_stream(80);
    rst_b = 0;
    repeat (2) @(negedge core_clk);
    ea = ACC_RST;
    ef = FLG_RST;
    ewd = ACC_RST;
    `CK("reset state", {ea, ef, ewd}, {acc, flags, mem_wr_data})
    `CK("reset strobes", 3'h1, {mem_wr_en, discard_prefetch, op_ready})
    rst_b = 1;
    run_stream(30);
    `CK("queue drained", 0, q.size())
    give_verdict();
  end
  // Watchdog
  initial begin #8000; fails++; give_verdict(); end
endmodule
`default_nettype wire
